//--- logic/tcp_pkg.sv
// Constants shared by the capture/compare timer: register map, field positions,
// reset values, mode and edge-select codes.
// Assumes a 32-bit APB slave with byte addresses and one register per aligned word.
package tcp_pkg;

    localparam int unsigned ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CAPCMP_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_OUTPUT_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRESCALER   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_COUNTER     = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CAPCMP_A    = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CAPCMP_B    = 8'h18;

    // mode_control_reg fields
    localparam int unsigned MC_OVF_BIT  = 0;
    localparam int unsigned MC_TOG_BIT  = 1;
    localparam int unsigned MC_MODE_LSB = 2;
    // capcmp_control_reg fields
    localparam int unsigned CC_A_CAP_BIT = 0;
    localparam int unsigned CC_A_OPP_BIT = 1;
    localparam int unsigned CC_B_CAP_BIT = 2;
    // output_control_reg fields
    localparam int unsigned OC_OUT_EN_BIT = 0;
    localparam int unsigned OC_INV_A_BIT  = 2;
    localparam int unsigned OC_INV_B_BIT  = 4;
    localparam int unsigned OC_OS_EN_BIT  = 5;
    localparam int unsigned OC_OS_TRG_BIT = 6;
    // prescaler_mode_reg fields
    localparam int unsigned PS_SEL_LSB  = 0;
    localparam int unsigned PS_ES_A_LSB = 4;
    localparam int unsigned PS_ES_B_LSB = 6;

    // Operating mode codes
    localparam logic [1:0] MODE_STOP      = 2'h0;
    localparam logic [1:0] MODE_FREE      = 2'h1;
    localparam logic [1:0] MODE_CLR_TRIG  = 2'h2;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h3;

    // Valid-edge select codes
    localparam logic [1:0] ES_FALL = 2'h0;
    localparam logic [1:0] ES_RISE = 2'h1;
    localparam logic [1:0] ES_NONE = 2'h2;
    localparam logic [1:0] ES_BOTH = 2'h3;

    // Prescaler divide limits (count clock = pclk / (limit + 1))
    localparam logic [5:0] PSC_LIM_0 = 6'h00;
    localparam logic [5:0] PSC_LIM_1 = 6'h03;
    localparam logic [5:0] PSC_LIM_2 = 6'h0F;
    localparam logic [5:0] PSC_LIM_3 = 6'h3F;

    // Reset values and counter maximum
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CAPCMP = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [1:0]  RST_ES    = ES_FALL;

endpackage

//--- logic/tcp_edge_detect.sv
// Two-flop synchroniser and edge detector for the two trigger inputs.
// Assumes trigger pins are asynchronous to pclk; pulses last one pclk cycle.
`timescale 1ns/1ps
module tcp_edge_detect
    import tcp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] rise,
    output logic      [1:0] fall
);

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
        logic [1:0] last;
    } tcp_edge_type;

    tcp_edge_type s_q;
    tcp_edge_type s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Edges come only from synchronised flops, never from the first stage
    for (genvar i = 0; i < 2; i++) begin : g_edge
        assign rise[i] = s_q.sync[i] & ~s_q.last[i];
        assign fall[i] = ~s_q.sync[i] & s_q.last[i];
    end

endmodule

//--- logic/tcp_timer.sv
// 16-bit capture/compare timer with periodic pulse and one-shot output, APB slave.
// Assumes trigger pins are asynchronous; APB master on pclk; zero-wait answers.
//
// Summary of operation
// - Dual capture in free-run leaves toggle_out unchanged unless capture toggling on.
// - With capture toggling on in dual capture and one-shot disabled, each valid trigger A edge inverts toggle_out.
// - Dual capture: trigger A edge loads register B, trigger B edge loads A.
// - If only trigger B edges are detected, register B never captures.
// - Compare match raises that register's match pulse; counter keeps counting except on A match in clear-on-A-match mode.
// - Register A captures on trigger B edge or opposite trigger A edge.
// - Register B captures the counter on each valid trigger A edge unless the timer is stopped.
// - Clear-on-A-match mode gives square wave: A sets period, B sets width.
// - Period is A+1 count clocks; high time is B+1 count clocks.
// - One-shot only in free-run or trigger-clear mode with one-shot enabled.
// - Software trigger or trigger A edge clears counter and starts one pulse.
// - During one-shot, A match and B match each raise their pulse and invert.
// - Pulse starts A+1 count clocks after trigger and lasts B-A clocks.
// - Free-run wraps after FFFF to 0000 and sets the overflow flag.
// - Trigger-clear mode captures into B and clears counter on trigger A edge.
// - Capture into A on the opposite trigger A edge raises no match A pulse.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tcp_timer
    import tcp_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              trigger_in_a,
    input  wire logic              trigger_in_b,
    output logic                   toggle_out,
    output logic                   irq_match_a,
    output logic                   irq_match_b
);

    typedef struct packed {
        logic [15:0] up_counter;
        logic [15:0] capcmp_reg_a;
        logic [15:0] capcmp_reg_b;
        logic        overflow_flag;
        logic        capture_toggle_en;
        logic [1:0]  op_mode;
        logic        a_capture;
        logic        a_opp_edge;
        logic        b_capture;
        logic        out_en;
        logic        inv_on_a;
        logic        inv_on_b;
        logic        oneshot_enable;
        logic [1:0]  psc_sel;
        logic [1:0]  edge_sel_a;
        logic [1:0]  edge_sel_b;
        logic [5:0]  psc_cnt;
        logic        os_busy;
        logic        out;
        logic        irq_a;
        logic        irq_b;
        logic [31:0] rdata;
    } tcp_state_type;

    tcp_state_type s_q;
    tcp_state_type s_d;

    logic [1:0] rise;
    logic [1:0] fall;
    logic       apb_wr;
    logic       apb_setup;
    logic       mapped;
    logic       tick;
    logic [5:0] psc_lim;
    logic       ea_valid;
    logic       ea_opp;
    logic       eb_valid;
    logic       match_a;
    logic       match_b;
    logic       oneshot_ok;
    logic       sw_trig;
    logic       os_trig;
    logic       clr_trig;
    logic       dual_cap;

    tcp_edge_detect u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({trigger_in_b, trigger_in_a}),
        .rise    (rise),
        .fall    (fall)
    );

    function automatic logic edge_hit(input logic [1:0] es, input logic r, input logic f);
        logic hit;
        hit = 1'b0;
        case (es)
            ES_FALL: hit = f;
            ES_RISE: hit = r;
            ES_BOTH: hit = r | f;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign apb_wr    = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign mapped    = (paddr == OFF_MODE_CTRL) || (paddr == OFF_CAPCMP_CTRL)
                    || (paddr == OFF_OUTPUT_CTRL) || (paddr == OFF_PRESCALER)
                    || (paddr == OFF_COUNTER) || (paddr == OFF_CAPCMP_A)
                    || (paddr == OFF_CAPCMP_B);
    // Zero-wait slave: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;

    always_comb begin
        case (s_q.psc_sel)
            2'h0:    psc_lim = PSC_LIM_0;
            2'h1:    psc_lim = PSC_LIM_1;
            2'h2:    psc_lim = PSC_LIM_2;
            default: psc_lim = PSC_LIM_3;
        endcase
    end

    assign tick       = (s_q.op_mode != MODE_STOP) && (s_q.psc_cnt == psc_lim);
    assign ea_valid   = edge_hit(s_q.edge_sel_a, rise[0], fall[0]);
    assign eb_valid   = edge_hit(s_q.edge_sel_b, rise[1], fall[1]);
    // Opposite phase of trigger A: rising when falling is valid and vice versa
    assign ea_opp     = edge_hit(s_q.edge_sel_a, fall[0], rise[0]);
    assign match_a    = tick && !s_q.a_capture && (s_q.up_counter == s_q.capcmp_reg_a);
    assign match_b    = tick && !s_q.b_capture && (s_q.up_counter == s_q.capcmp_reg_b);
    assign oneshot_ok = s_q.oneshot_enable
                     && ((s_q.op_mode == MODE_FREE) || (s_q.op_mode == MODE_CLR_TRIG));
    assign sw_trig    = apb_wr && (paddr == OFF_OUTPUT_CTRL) && pwdata[OC_OS_TRG_BIT];
    assign os_trig    = oneshot_ok && (sw_trig || ea_valid);
    assign clr_trig   = (s_q.op_mode == MODE_CLR_TRIG) && ea_valid;
    assign dual_cap   = (s_q.op_mode == MODE_FREE) && s_q.a_capture && s_q.b_capture;

    always_comb begin
        s_d       = s_q;
        s_d.irq_a = 1'b0;
        s_d.irq_b = 1'b0;

        // Register writes first, so hardware events below win over them
        if (apb_wr) begin
            if (paddr == OFF_MODE_CTRL) begin
                s_d.overflow_flag     = pwdata[MC_OVF_BIT];
                s_d.capture_toggle_en = pwdata[MC_TOG_BIT];
                s_d.op_mode           = pwdata[MC_MODE_LSB +: 2];
            end else if (paddr == OFF_CAPCMP_CTRL) begin
                s_d.a_capture  = pwdata[CC_A_CAP_BIT];
                s_d.a_opp_edge = pwdata[CC_A_OPP_BIT];
                s_d.b_capture  = pwdata[CC_B_CAP_BIT];
            end else if (paddr == OFF_OUTPUT_CTRL) begin
                s_d.out_en         = pwdata[OC_OUT_EN_BIT];
                s_d.inv_on_a       = pwdata[OC_INV_A_BIT];
                s_d.inv_on_b       = pwdata[OC_INV_B_BIT];
                s_d.oneshot_enable = pwdata[OC_OS_EN_BIT];
            end else if (paddr == OFF_PRESCALER) begin
                s_d.psc_sel    = pwdata[PS_SEL_LSB +: 2];
                s_d.edge_sel_a = pwdata[PS_ES_A_LSB +: 2];
                s_d.edge_sel_b = pwdata[PS_ES_B_LSB +: 2];
            end else if (paddr == OFF_CAPCMP_A) begin
                s_d.capcmp_reg_a = pwdata[15:0];
            end else if (paddr == OFF_CAPCMP_B) begin
                s_d.capcmp_reg_b = pwdata[15:0];
            end
        end

        // Prescaler and counter
        if (s_q.op_mode == MODE_STOP) begin
            s_d.psc_cnt    = 6'h00;
            s_d.up_counter = RST_COUNT;
            s_d.os_busy    = 1'b0;
        end else begin
            s_d.psc_cnt = tick ? 6'h00 : 6'(s_q.psc_cnt + 6'h01);
            if (clr_trig || os_trig) begin
                s_d.up_counter = RST_COUNT;
            end else if (tick) begin
                if ((s_q.op_mode == MODE_CLR_MATCH) && (s_q.up_counter == s_q.capcmp_reg_a)) begin
                    s_d.up_counter = RST_COUNT;
                end else if (s_q.up_counter == CNT_MAX) begin
                    s_d.up_counter    = RST_COUNT;
                    s_d.overflow_flag = 1'b1;
                end else begin
                    s_d.up_counter = 16'(s_q.up_counter + 16'h0001);
                end
            end

            // Captures take the count before any clear of the same cycle
            if (s_q.a_capture && (s_q.a_opp_edge ? ea_opp : eb_valid)) begin
                s_d.capcmp_reg_a = s_q.up_counter;
                s_d.irq_a        = !s_q.a_opp_edge;
            end
            if (s_q.b_capture && ea_valid) begin
                s_d.capcmp_reg_b = s_q.up_counter;
                s_d.irq_b        = 1'b1;
            end
        end

        if (match_a) begin
            s_d.irq_a = 1'b1;
        end
        if (match_b) begin
            s_d.irq_b = 1'b1;
        end

        // Output pin; the match acts when the count leaves the compare value
        if (!s_q.out_en) begin
            s_d.out = 1'b0;
        end else if (s_q.op_mode == MODE_CLR_MATCH) begin
            if (match_a) begin
                s_d.out = 1'b1;
            end else if (match_b) begin
                s_d.out = 1'b0;
            end
        end else if (oneshot_ok) begin
            // A retrigger mid-pulse only restarts the count; the pin is not reset
            if (os_trig) begin
                s_d.os_busy = 1'b1;
            end else if (s_q.os_busy && (match_a ^ match_b)) begin
                s_d.out     = ~s_q.out;
                s_d.os_busy = !match_b;
            end
        end else if (dual_cap) begin
            if (s_q.capture_toggle_en && ea_valid) begin
                s_d.out = ~s_q.out;
            end
        end else if ((match_a && s_q.inv_on_a) ^ (match_b && s_q.inv_on_b)) begin
            s_d.out = ~s_q.out;
        end

        // Read data is sampled in the setup cycle and held through access
        if (apb_setup && !pwrite) begin
            s_d.rdata = 32'h0000_0000;
            if (paddr == OFF_MODE_CTRL) begin
                s_d.rdata[MC_OVF_BIT]      = s_q.overflow_flag;
                s_d.rdata[MC_TOG_BIT]      = s_q.capture_toggle_en;
                s_d.rdata[MC_MODE_LSB +: 2] = s_q.op_mode;
            end else if (paddr == OFF_CAPCMP_CTRL) begin
                s_d.rdata[CC_A_CAP_BIT] = s_q.a_capture;
                s_d.rdata[CC_A_OPP_BIT] = s_q.a_opp_edge;
                s_d.rdata[CC_B_CAP_BIT] = s_q.b_capture;
            end else if (paddr == OFF_OUTPUT_CTRL) begin
                s_d.rdata[OC_OUT_EN_BIT] = s_q.out_en;
                s_d.rdata[OC_INV_A_BIT]  = s_q.inv_on_a;
                s_d.rdata[OC_INV_B_BIT]  = s_q.inv_on_b;
                s_d.rdata[OC_OS_EN_BIT]  = s_q.oneshot_enable;
            end else if (paddr == OFF_PRESCALER) begin
                s_d.rdata[PS_SEL_LSB +: 2]  = s_q.psc_sel;
                s_d.rdata[PS_ES_A_LSB +: 2] = s_q.edge_sel_a;
                s_d.rdata[PS_ES_B_LSB +: 2] = s_q.edge_sel_b;
            end else if (paddr == OFF_COUNTER) begin
                s_d.rdata[15:0] = s_q.up_counter;
            end else if (paddr == OFF_CAPCMP_A) begin
                s_d.rdata[15:0] = s_q.capcmp_reg_a;
            end else if (paddr == OFF_CAPCMP_B) begin
                s_d.rdata[15:0] = s_q.capcmp_reg_b;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q              <= '0;
            s_q.capcmp_reg_a <= RST_CAPCMP;
            s_q.capcmp_reg_b <= RST_CAPCMP;
            s_q.edge_sel_a   <= RST_ES;
            s_q.edge_sel_b   <= RST_ES;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata      = s_q.rdata;
    assign toggle_out  = s_q.out;
    assign irq_match_a = s_q.irq_a;
    assign irq_match_b = s_q.irq_b;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_os_start;
        os_trig && s_q.out_en && !s_q.os_busy;
    endsequence

    sequence s_os_first_match;
        s_q.os_busy && oneshot_ok && s_q.out_en && match_a && !match_b && !os_trig;
    endsequence

    a_dual_cap_hold: assert property (dual_cap && !s_q.capture_toggle_en && !apb_wr
        |=> $stable(toggle_out)) else $error("output moved in dual capture");
    a_cap_toggle_a: assert property (dual_cap && s_q.capture_toggle_en && s_q.out_en
        && !oneshot_ok && ea_valid |=> toggle_out != $past(toggle_out))
        else $error("trigger A edge did not invert output");
    a_cap_load_b: assert property (s_q.b_capture && s_q.op_mode != MODE_STOP && ea_valid
        |=> s_q.capcmp_reg_b == $past(s_q.up_counter) && irq_match_b)
        else $error("register B capture missing");
    a_cap_load_a: assert property (s_q.a_capture && !s_q.a_opp_edge
        && s_q.op_mode != MODE_STOP && eb_valid
        |=> s_q.capcmp_reg_a == $past(s_q.up_counter) && irq_match_a)
        else $error("register A capture missing");
    a_match_no_clear: assert property (match_a && s_q.op_mode == MODE_FREE && !os_trig
        && !apb_wr |=> irq_match_a && s_q.up_counter == 16'($past(s_q.up_counter) + 16'h0001))
        else $error("compare match cleared counter or lost pulse");
    a_ppg_restart: assert property (match_a && s_q.op_mode == MODE_CLR_MATCH
        && s_q.out_en && !apb_wr |=> s_q.up_counter == RST_COUNT && toggle_out)
        else $error("periodic pulse did not restart high");
    a_ppg_width_end: assert property (match_b && !match_a && s_q.op_mode == MODE_CLR_MATCH
        && !apb_wr |=> !toggle_out) else $error("periodic pulse did not end at B match");
    a_ovf_wrap: assert property (tick && s_q.op_mode == MODE_FREE && !os_trig
        && s_q.up_counter == CNT_MAX |=> s_q.overflow_flag && s_q.up_counter == RST_COUNT)
        else $error("overflow wrap wrong");
    a_oneshot_gate: assert property ($rose(s_q.os_busy) |-> $past(oneshot_ok))
        else $error("one-shot started outside allowed modes");
    a_oneshot_first: assert property (s_os_start
        |=> s_q.up_counter == RST_COUNT && s_q.os_busy)
        else $error("one-shot trigger did not clear counter");
    a_oneshot_invert: assert property (s_os_first_match
        |=> toggle_out != $past(toggle_out) && irq_match_a)
        else $error("one-shot A match did not invert");
    a_opp_no_irq: assert property (s_q.a_capture && s_q.a_opp_edge
        |=> !irq_match_a) else $error("opposite edge capture raised match A");
    a_count_hold: assert property (s_q.op_mode != MODE_STOP && !tick && !clr_trig
        && !os_trig |=> $stable(s_q.up_counter)) else $error("counter moved without tick");

endmodule

//--- bench/tcp_pin_src.sv
// Far-side model: two external pulse sources on the trigger pins.
// Assumes one-cycle flip requests from the bench, spaced well apart.
`timescale 1ns/1ps
module tcp_pin_src (
    input  wire logic pclk,
    input  wire logic flip_a,
    input  wire logic flip_b,
    output logic      trigger_in_a,
    output logic      trigger_in_b
);
    // Pins move only on request, so software-only triggering sees pin A steady
    initial begin
        trigger_in_a = 1'b0;
        trigger_in_b = 1'b0;
    end
    // Levels hold for many cycles, longer than the synchroniser needs
    always @(posedge pclk) begin
        if (flip_a) begin
            trigger_in_a <= ~trigger_in_a;
        end
        if (flip_b) begin
            trigger_in_b <= ~trigger_in_b;
        end
    end
endmodule

//--- bench/tcp_timer_tb_top.sv
// Self-checking bench for the capture/compare timer.
// Assumes the zero-wait APB slave and the pin model in tcp_pin_src.
`timescale 1ns/1ps
module tcp_timer_tb_top
    import tcp_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, flip_a, flip_b, err;
    logic              pready, pslverr, toggle_out, irq_match_a, irq_match_b, tin_a, tin_b;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rv;
    logic [63:0]       exp_q[$];
    logic [63:0]       ent;
    int                error_cnt, checks_done, cyc, ia, ib, n1, n2, pa, pb, t0;

    tcp_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_in_a(tin_a), .trigger_in_b(tin_b),
        .toggle_out(toggle_out), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b));
    tcp_pin_src i_pins (.pclk(pclk), .flip_a(flip_a), .flip_b(flip_b),
        .trigger_in_a(tin_a), .trigger_in_b(tin_b));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    // Read expectations go to the queue; the watcher below compares them
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        if (!w) exp_q.push_back({m, d});
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq_match_a === 1'b1) ia <= ia + 1;
        if (irq_match_b === 1'b1) ib <= ib + 1;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            chk("prdata", ent[31:0] & ent[63:32], prdata & ent[63:32]);
        end
    end

    task automatic flip(input bit b, input int settle);
        @(posedge pclk);
        if (b) flip_b <= 1'b1;
        else flip_a <= 1'b1;
        @(posedge pclk);
        flip_a <= 1'b0;
        flip_b <= 1'b0;
        repeat (settle) @(posedge pclk);
    endtask

    // Counts settled half-cycle samples until toggle_out reaches v
    task automatic wait_lvl(input logic v, input int lim, output int n);
        n = 0;
        while (toggle_out !== v && n < lim) begin
            @(negedge pclk);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, flip_a, flip_b, paddr, pwdata} = '0;
        {error_cnt, checks_done, cyc, ia, ib} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'hE2CD6F74));
        apb(0, OFF_MODE_CTRL, 32'h0, '1);
        apb(0, OFF_COUNTER, 32'h0, '1);
        chk("toggle_out", 1'b0, toggle_out);
        apb(0, 8'h1C, 32'h0, '1);
        chk("pslverr", 1'b1, err);
        apb(1, OFF_COUNTER, 32'h1234, 0);
        apb(0, OFF_COUNTER, 32'h0, '1);
        $display("test reset done");
        apb(1, OFF_PRESCALER, 32'hF0, 0);
        apb(1, OFF_CAPCMP_CTRL, 32'h05, 0);
        apb(1, OFF_OUTPUT_CTRL, 32'h01, 0);
        apb(1, OFF_MODE_CTRL, 32'h04, 0);
        t0 = cyc;
        repeat (20) @(posedge pclk);
        pa = cyc - t0;
        flip(0, 12);
        apb(0, OFF_CAPCMP_B, 32'h0, 0);
        chk("cap_b", 1, 32'(rv >= pa && rv <= pa + 10));
        chk("toggle_out", 1'b0, toggle_out);
        pa = cyc - t0;
        flip(1, 12);
        apb(0, OFF_CAPCMP_A, 32'h0, 0);
        chk("cap_a", 1, 32'(rv >= pa && rv <= pa + 10));
        apb(1, OFF_MODE_CTRL, 32'h06, 0);
        flip(0, 12);
        chk("toggle_out", 1'b1, toggle_out);
        apb(1, OFF_PRESCALER, 32'hE0, 0);
        apb(0, OFF_CAPCMP_B, 32'h0, 0);
        pb = rv;
        flip(0, 12);
        apb(0, OFF_CAPCMP_B, pb, '1);
        apb(1, OFF_PRESCALER, 32'hF0, 0);
        apb(1, OFF_CAPCMP_CTRL, 32'h07, 0);
        pa = ia;
        flip(0, 12);
        chk("opp_irq_a", pa, ia);
        apb(0, OFF_CAPCMP_A, 32'h0, 0);
        apb(0, OFF_CAPCMP_B, rv, '1);
        $display("test dual capture done");
        pa = 4 + $urandom % 12;
        pb = $urandom % pa;
        apb(1, OFF_MODE_CTRL, 32'h0, 0);
        apb(1, OFF_PRESCALER, 32'hF1, 0);
        apb(1, OFF_CAPCMP_CTRL, 32'h0, 0);
        apb(1, OFF_CAPCMP_A, pa, 0);
        apb(1, OFF_CAPCMP_B, pb, 0);
        apb(1, OFF_OUTPUT_CTRL, 32'h15, 0);
        apb(1, OFF_MODE_CTRL, 32'h0C, 0);
        wait_lvl(0, 200, n1);
        wait_lvl(1, 200, n1);
        wait_lvl(0, 200, n1);
        wait_lvl(1, 200, n2);
        chk("ppg_high", (pb + 1) * (int'(PSC_LIM_1) + 1), n1);
        chk("ppg_period", (pa + 1) * (int'(PSC_LIM_1) + 1), n1 + n2);
        $display("test periodic pulse done");
        apb(1, OFF_MODE_CTRL, 32'h0, 0);
        apb(1, OFF_OUTPUT_CTRL, 32'h0, 0);
        apb(1, OFF_CAPCMP_A, 32'h5, 0);
        apb(1, OFF_CAPCMP_B, 32'hC, 0);
        apb(1, OFF_PRESCALER, 32'hF0, 0);
        apb(1, OFF_OUTPUT_CTRL, 32'h35, 0);
        apb(1, OFF_MODE_CTRL, 32'h04, 0);
        pa = ia;
        pb = ib;
        apb(1, OFF_OUTPUT_CTRL, 32'h75, 0);
        wait_lvl(1, 100, n2);
        wait_lvl(0, 100, n1);
        chk("os_delay", 1, 32'(n2 >= 4 && n2 <= 8));
        chk("os_width", 7, n1);
        repeat (2) @(posedge pclk);
        chk("os_irq", 2, ia - pa + ib - pb);
        repeat (20) @(posedge pclk);
        flip(0, 0);
        wait_lvl(1, 100, n2);
        wait_lvl(0, 100, n1);
        chk("os_pin_width", 7, n1);
        apb(1, OFF_MODE_CTRL, 32'h0, 0);
        apb(1, OFF_OUTPUT_CTRL, 32'h75, 0);
        wait_lvl(1, 40, n1);
        chk("os_stopped", 40, n1);
        $display("test one-shot done");
        apb(1, OFF_OUTPUT_CTRL, 32'h0, 0);
        apb(1, OFF_MODE_CTRL, 32'h04, 0);
        repeat (65545) @(posedge pclk);
        apb(0, OFF_MODE_CTRL, 32'h1, 32'h1);
        apb(1, OFF_MODE_CTRL, 32'h04, 0);
        apb(0, OFF_MODE_CTRL, 32'h04, '1);
        $display("test overflow done");
        finish_test();
    end
endmodule
